// *** include/bwa_pkg.sv ***
// bwa_pkg: constants shared by the binary word arithmetic unit and its divider
// assumes: nothing beyond a SystemVerilog compiler
package bwa_pkg;
    // word width and divider step count
    localparam int WORD_W = 16;
    localparam int DIV_STEPS = 16;
    // instruction codes from the sequencer
    typedef enum logic [1:0] {
        BWA_OP_ADD = 2'h0,
        BWA_OP_SUB = 2'h1,
        BWA_OP_MUL = 2'h2,
        BWA_OP_DIV = 2'h3
    } bwa_op_t;
    // operand areas; immediate is source only
    typedef enum logic [2:0] {
        BWA_AREA_IO = 3'h0,
        BWA_AREA_SPECIAL = 3'h1,
        BWA_AREA_AUX = 3'h2,
        BWA_AREA_DATA = 3'h3,
        BWA_AREA_HOLD = 3'h4,
        BWA_AREA_TIMER = 3'h5,
        BWA_AREA_LINK = 3'h6,
        BWA_AREA_IMM = 3'h7
    } bwa_area_t;
    // unit state
    typedef enum logic {
        BWA_ST_IDLE = 1'b0,
        BWA_ST_DIV = 1'b1
    } bwa_state_t;
    // carry flag home in the special area: word 255, bit 04
    localparam logic [7:0] CARRY_SPECIAL_WORD = 8'hFF;
    localparam logic [3:0] CARRY_SPECIAL_BIT = 4'h4;
    // register byte offsets
    localparam logic [4:0] REG_CARRY_CTRL = 5'h00;
    localparam logic [4:0] REG_FLAGS = 5'h04;
    localparam logic [4:0] REG_INT_STATUS = 5'h08;
    localparam logic [4:0] REG_INT_CLEAR = 5'h0C;
    localparam logic [4:0] REG_INT_ENABLE = 5'h10;
    // field positions
    localparam int CTRL_SET_CARRY_BIT = 0;
    localparam int CTRL_CLR_CARRY_BIT = 1;
    localparam int EV_DONE_BIT = 0;
    localparam int EV_ERROR_BIT = 1;
    localparam int EV_W = 2;
    // reset values
    localparam logic [EV_W-1:0] INT_ENABLE_RST = 2'h0;
    localparam logic CARRY_RST = 1'b0;
endpackage

// *** core/bwa_divider.sv ***
// bwa_divider: restoring divider, one quotient bit per enabled clock
// assumes: divisor is non-zero at start; start only while idle
`timescale 1ns/10ps
`default_nettype none
module bwa_divider #(
    parameter int W = bwa_pkg::WORD_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // request
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    // answer
    output logic done,
    output logic [W-1:0] quot,
    output logic [W-1:0] rem
);
    localparam int CW = $clog2(W + 1);
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic [W-1:0] quot_ff, nxt_quot;
    logic [W-1:0] rem_ff, nxt_rem;
    logic [W-1:0] dvsr_ff, nxt_dvsr;
    logic [W:0] shifted;
    logic [W:0] trial;

    // one restoring step per cycle
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_quot = quot_ff;
        nxt_rem = rem_ff;
        nxt_dvsr = dvsr_ff;
        shifted = {rem_ff, quot_ff[W-1]};
        trial = shifted - {1'b0, dvsr_ff};
        if (start && !busy_ff)
        begin
            nxt_busy = 1'b1;
            nxt_cnt = '0;
            nxt_quot = dividend;
            nxt_rem = '0;
            nxt_dvsr = divisor;
        end
        else if (busy_ff)
        begin
            if (!trial[W])
            begin
                nxt_rem = trial[W-1:0];
                nxt_quot = {quot_ff[W-2:0], 1'b1};
            end
            else
            begin
                nxt_rem = shifted[W-1:0];
                nxt_quot = {quot_ff[W-2:0], 1'b0};
            end
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == CW'(W - 1))
            begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end
        end
    end

    // register the step
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            quot_ff <= '0;
            rem_ff <= '0;
            dvsr_ff <= '0;
        end
        else if (clk_en)
        begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            quot_ff <= nxt_quot;
            rem_ff <= nxt_rem;
            dvsr_ff <= nxt_dvsr;
        end
    end

    assign done = done_ff;
    assign quot = quot_ff;
    assign rem = rem_ff;
endmodule // bwa_divider
`default_nettype wire

// *** core/bwa_unit.sv ***
// bwa_unit: 16-bit binary add, subtract, multiply and divide for the sequencer
// assumes: sequencer on core_clk, presents one instruction while op_busy is low
// Notes on behaviour
// (RULE1) condition false: nothing written, flags kept
// (RULE2) add sums both words plus carry
// (RULE3) add carry set when sum exceeds FFFF
// (RULE4) subtract removes subtrahend and carry from minuend
// (RULE5) negative difference stored modulo 16 bits, carry set
// (RULE6) subtract carry when minuend below subtrahend plus carry
// (RULE7) multiply gives 32-bit product, low then high
// (RULE8) divide stores quotient then remainder
// (RULE9) zero divisor raises error flag
// (RULE10) missing indirect data word raises error flag
// (RULE11) zero flag follows zero result
// (RULE12) sources any area, destinations restricted
// (RULE13) operands are unsigned 16-bit words
// (RULE14) carry lives at special bit 25504
// (RULE15) software may set or clear carry
// (RULE16) data treated as hex, never decimal-coded
// (RULE17) differentiated form runs on rising condition
// (RULE18) error leaves destination words untouched
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module bwa_unit #(
    parameter int W = bwa_pkg::WORD_W
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // instruction from the sequencer
    input wire logic op_valid,
    input wire logic [1:0] op_code,
    input wire logic exec_cond,
    input wire logic op_diff,
    input wire logic [2:0] dst_area,
    input wire logic ptr_fault,
    input wire logic [W-1:0] operand_a,
    input wire logic [W-1:0] operand_b,
    // results to the sequencer
    output logic op_busy,
    output logic res_done,
    output logic res_lo_we,
    output logic res_hi_we,
    output logic [W-1:0] res_lo,
    output logic [W-1:0] res_hi,
    // flags
    output logic carry_flag,
    output logic zero_flag,
    output logic error_flag,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    // destination must be a writable area
    function automatic logic dst_ok(input logic [2:0] area);
        unique case (bwa_pkg::bwa_area_t'(area))
            bwa_pkg::BWA_AREA_IO, bwa_pkg::BWA_AREA_AUX, bwa_pkg::BWA_AREA_DATA,
            bwa_pkg::BWA_AREA_HOLD, bwa_pkg::BWA_AREA_LINK: dst_ok = 1'b1;
            default: dst_ok = 1'b0;
        endcase
    endfunction

    bwa_pkg::bwa_state_t state_ff, nxt_state;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic lo_we_ff, nxt_lo_we;
    logic hi_we_ff, nxt_hi_we;
    logic [W-1:0] lo_ff, nxt_lo;
    logic [W-1:0] hi_ff, nxt_hi;
    logic carry_ff, nxt_carry;
    logic zero_ff, nxt_zero;
    logic err_ff, nxt_err;
    logic [3:0] prev_cond_ff, nxt_prev_cond;
    logic [W-1:0] div_a_ff, nxt_div_a;
    logic [W-1:0] div_b_ff, nxt_div_b;
    logic [bwa_pkg::EV_W-1:0] ev;
    logic [bwa_pkg::EV_W-1:0] int_stat_ff, nxt_int_stat;
    logic [bwa_pkg::EV_W-1:0] int_en_ff, nxt_int_en;
    logic irq_ff, nxt_irq;
    logic [31:0] rdata_ff, nxt_rdata;
    logic accept, run_now, fault_now;
    logic [W:0] sum_full;
    logic [W:0] diff_full;
    logic [2*W-1:0] product;
    logic div_start, div_done;
    logic [W-1:0] div_quot, div_rem;
    logic sw_set_carry, sw_clr_carry;

    // plain unsigned arithmetic on hex words
    assign sum_full = {1'b0, operand_a} + {1'b0, operand_b} + {{W{1'b0}}, carry_ff}; // RULE2 RULE13 RULE16
    assign diff_full = {1'b0, operand_a} - {1'b0, operand_b} - {{W{1'b0}}, carry_ff}; // RULE4 RULE5
    assign product = {{W{1'b0}}, operand_a} * {{W{1'b0}}, operand_b}; // RULE7
    // request decode
    assign accept = op_valid && (state_ff == bwa_pkg::BWA_ST_IDLE);
    assign run_now = exec_cond && !(op_diff && prev_cond_ff[op_code]); // RULE1 RULE17
    assign fault_now = ptr_fault || !dst_ok(dst_area); // RULE10 RULE12
    assign sw_set_carry = reg_wr && (reg_addr == bwa_pkg::REG_CARRY_CTRL)
        && reg_wdata[bwa_pkg::CTRL_SET_CARRY_BIT];
    assign sw_clr_carry = reg_wr && (reg_addr == bwa_pkg::REG_CARRY_CTRL)
        && reg_wdata[bwa_pkg::CTRL_CLR_CARRY_BIT];

    // instruction execution and flag update
    always_comb
    begin
        nxt_state = state_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_lo_we = 1'b0;
        nxt_hi_we = 1'b0;
        nxt_lo = lo_ff;
        nxt_hi = hi_ff;
        nxt_carry = carry_ff;
        nxt_zero = zero_ff;
        nxt_err = err_ff;
        nxt_prev_cond = prev_cond_ff;
        nxt_div_a = div_a_ff;
        nxt_div_b = div_b_ff;
        div_start = 1'b0;
        ev = '0;
        // software carry control; an add or subtract in the same cycle wins
        if (sw_set_carry)
            nxt_carry = 1'b1; // RULE15
        else if (sw_clr_carry)
            nxt_carry = 1'b0; // RULE15
        unique case (state_ff)
            bwa_pkg::BWA_ST_IDLE:
            begin
                if (accept)
                begin
                    nxt_prev_cond[op_code] = exec_cond;
                    nxt_done = 1'b1;
                    if (run_now)
                    begin
                        nxt_err = 1'b0;
                        if (fault_now)
                            nxt_err = 1'b1; // RULE10 RULE18
                        else
                        begin
                            unique case (bwa_pkg::bwa_op_t'(op_code))
                                bwa_pkg::BWA_OP_ADD:
                                begin
                                    nxt_lo = sum_full[W-1:0]; // RULE2
                                    nxt_lo_we = 1'b1;
                                    nxt_carry = sum_full[W]; // RULE3
                                    nxt_zero = (sum_full[W-1:0] == '0); // RULE11
                                end
                                bwa_pkg::BWA_OP_SUB:
                                begin
                                    nxt_lo = diff_full[W-1:0]; // RULE4 RULE5
                                    nxt_lo_we = 1'b1;
                                    nxt_carry = diff_full[W]; // RULE6
                                    nxt_zero = (diff_full[W-1:0] == '0); // RULE11
                                end
                                bwa_pkg::BWA_OP_MUL:
                                begin
                                    nxt_lo = product[W-1:0]; // RULE7
                                    nxt_hi = product[2*W-1:W];
                                    nxt_lo_we = 1'b1;
                                    nxt_hi_we = 1'b1;
                                    nxt_zero = (product == '0); // RULE11
                                end
                                bwa_pkg::BWA_OP_DIV:
                                begin
                                    if (operand_b == '0)
                                        nxt_err = 1'b1; // RULE9 RULE18
                                    else
                                    begin
                                        nxt_done = 1'b0;
                                        div_start = 1'b1;
                                        nxt_div_a = operand_a;
                                        nxt_div_b = operand_b;
                                        nxt_busy = 1'b1;
                                        nxt_state = bwa_pkg::BWA_ST_DIV;
                                    end
                                end
                            endcase
                        end
                    end
                end
            end
            bwa_pkg::BWA_ST_DIV:
            begin
                if (div_done)
                begin
                    nxt_lo = div_quot; // RULE8
                    nxt_hi = div_rem;
                    nxt_lo_we = 1'b1;
                    nxt_hi_we = 1'b1;
                    nxt_zero = (div_quot == '0); // RULE11
                    nxt_done = 1'b1;
                    nxt_busy = 1'b0;
                    nxt_state = bwa_pkg::BWA_ST_IDLE;
                end
            end
        endcase
        ev[bwa_pkg::EV_DONE_BIT] = nxt_done;
        ev[bwa_pkg::EV_ERROR_BIT] = nxt_done && nxt_err && (accept || div_done) && run_now;
    end

    // execution state registers; carry flag is special-area bit 25504
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= bwa_pkg::BWA_ST_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            lo_we_ff <= 1'b0;
            hi_we_ff <= 1'b0;
            lo_ff <= '0;
            hi_ff <= '0;
            carry_ff <= bwa_pkg::CARRY_RST; // RULE14
            zero_ff <= 1'b0;
            err_ff <= 1'b0;
            prev_cond_ff <= '0;
            div_a_ff <= '0;
            div_b_ff <= '0;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            lo_we_ff <= nxt_lo_we;
            hi_we_ff <= nxt_hi_we;
            lo_ff <= nxt_lo;
            hi_ff <= nxt_hi;
            carry_ff <= nxt_carry; // RULE14
            zero_ff <= nxt_zero;
            err_ff <= nxt_err;
            prev_cond_ff <= nxt_prev_cond;
            div_a_ff <= nxt_div_a;
            div_b_ff <= nxt_div_b;
        end
    end

    // sequential divider
    bwa_divider #(
        .W(W)
    ) u_div (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .start(div_start),
        .dividend(operand_a),
        .divisor(operand_b),
        .done(div_done),
        .quot(div_quot),
        .rem(div_rem)
    );

    // register port, interrupt status, read data for one cycle
    always_comb
    begin
        nxt_int_en = int_en_ff;
        nxt_int_stat = int_stat_ff;
        nxt_rdata = 32'h0000_0000;
        if (reg_wr && reg_addr == bwa_pkg::REG_INT_ENABLE)
            nxt_int_en = reg_wdata[bwa_pkg::EV_W-1:0];
        if (reg_wr && reg_addr == bwa_pkg::REG_INT_CLEAR)
            nxt_int_stat = nxt_int_stat & ~reg_wdata[bwa_pkg::EV_W-1:0];
        nxt_int_stat = nxt_int_stat | ev; // set wins over clear
        nxt_irq = |(nxt_int_stat & nxt_int_en);
        if (reg_rd)
        begin
            unique case (reg_addr)
                bwa_pkg::REG_FLAGS: nxt_rdata = {28'h0000000, busy_ff, err_ff, zero_ff, carry_ff};
                bwa_pkg::REG_INT_STATUS: nxt_rdata = {30'h00000000, int_stat_ff};
                bwa_pkg::REG_INT_ENABLE: nxt_rdata = {30'h00000000, int_en_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // register group flops
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            int_en_ff <= bwa_pkg::INT_ENABLE_RST;
            int_stat_ff <= '0;
            irq_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            int_en_ff <= nxt_int_en;
            int_stat_ff <= nxt_int_stat;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs straight from flops
    assign op_busy = busy_ff;
    assign res_done = done_ff;
    assign res_lo_we = lo_we_ff;
    assign res_hi_we = hi_we_ff;
    assign res_lo = lo_ff;
    assign res_hi = hi_ff;
    assign carry_flag = carry_ff;
    assign zero_flag = zero_ff;
    assign error_flag = err_ff;
    assign reg_rdata = rdata_ff;
    assign irq = irq_ff;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic ok_go;
    assign ok_go = clk_en && accept && run_now && !fault_now;

    noop_hold_a: assert property (clk_en && accept && !exec_cond |=> // RULE1
        !res_lo_we && !res_hi_we && $stable(zero_flag) && $stable(error_flag))
        else $error("false condition changed results");
    add_sum_a: assert property (ok_go && op_code == 2'h0 |=> res_lo_we && // RULE2
        res_lo == W'($past(operand_a) + $past(operand_b) + W'($past(carry_flag))))
        else $error("add result wrong");
    add_carry_a: assert property (ok_go && op_code == 2'h0 && !reg_wr |=> // RULE3
        carry_flag == (({1'b0, $past(operand_a)} + {1'b0, $past(operand_b)} + $past(carry_flag)) > 'hFFFF)
        && zero_flag == (res_lo == '0))
        else $error("add carry or zero wrong");
    sub_result_a: assert property (ok_go && op_code == 2'h1 |=> // RULE4
        res_lo == W'($past(operand_a) - $past(operand_b) - W'($past(carry_flag))))
        else $error("subtract result wrong");
    sub_borrow_a: assert property (ok_go && op_code == 2'h1 |=> // RULE6
        carry_flag == ({1'b0, $past(operand_a)} < {1'b0, $past(operand_b)} + $past(carry_flag)))
        else $error("subtract carry wrong");
    mul_prod_a: assert property (ok_go && op_code == 2'h2 |=> res_lo_we && res_hi_we && // RULE7
        {res_hi, res_lo} == $past(operand_a) * $past(operand_b))
        else $error("product wrong");
    div_result_a: assert property (res_done && res_hi_we && !res_lo_we == 1'b0 && op_busy == 1'b0 // RULE8
        && $past(state_ff) == bwa_pkg::BWA_ST_DIV |-> (res_lo * div_b_ff) + res_hi == div_a_ff && res_hi < div_b_ff)
        else $error("quotient or remainder wrong");
    div_time_a: assert property ($rose(op_busy) |-> ##[1:40] res_done) // RULE8
        else $error("divide never finished");
    div_zero_a: assert property (ok_go && op_code == 2'h3 && operand_b == '0 |=> // RULE9
        error_flag && !res_lo_we && !res_hi_we && res_done)
        else $error("zero divisor not flagged");
    ptr_err_a: assert property (clk_en && accept && run_now && ptr_fault |=> // RULE10
        error_flag && !res_lo_we && !res_hi_we)
        else $error("missing word not flagged");
    diff_once_a: assert property (clk_en && accept && op_diff && prev_cond_ff[op_code] |=> // RULE17
        !res_lo_we && !res_hi_we)
        else $error("differentiated form ran twice");
    add_cy_c: cover property (ok_go && op_code == 2'h0 ##1 carry_flag);
    sub_neg_c: cover property (ok_go && op_code == 2'h1 ##1 carry_flag);
    div_done_c: cover property ($rose(op_busy) ##[1:40] res_done && res_hi_we);
    err_irq_c: cover property (error_flag ##1 irq);
endmodule // bwa_unit
`default_nettype wire

// *** tb/bwa_dm_model.sv ***
// bwa_word_model: data memory words that the arithmetic unit writes back
// assumes: result words arrive with their write pulses on core_clk
`timescale 1ns/10ps
`default_nettype none
module bwa_word_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // result words from the unit
    input wire logic lo_we,
    input wire logic hi_we,
    input wire logic [3:0] dst_idx,
    input wire logic [15:0] lo,
    input wire logic [15:0] hi
);
    logic [15:0] mem_ff [0:15];
    // store words R and R+1; reset fills a pattern so a skipped write shows
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 16; i++)
            begin
                mem_ff[i] <= 16'hC3C3 ^ 16'(i);
            end
        end
        else
        begin
            if (lo_we)
            begin
                mem_ff[dst_idx] <= lo;
            end
            if (hi_we)
            begin
                mem_ff[dst_idx + 4'h1] <= hi;
            end
        end
    end
endmodule // bwa_word_model
`default_nettype wire

// *** tb/binary_word_arith_unit_tb_top.sv ***
// binary_word_arith_unit_tb_top: self-checking bench for the binary word unit
// assumes: bwa_pkg, bwa_divider, bwa_unit and bwa_word_model compiled first
`timescale 1ns/10ps
`default_nettype none
module binary_word_arith_unit_tb_top;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic op_valid = 1'b0, exec_cond = 1'b0, op_diff = 1'b0, ptr_fault = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0] op_code = 2'h0;
    logic [2:0] dst_area = 3'h3;
    logic [15:0] operand_a = 16'h0000, operand_b = 16'h0000, res_lo, res_hi;
    logic [4:0] reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic op_busy, res_done, res_lo_we, res_hi_we, carry_flag, zero_flag, error_flag, irq;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    bwa_unit dut (.core_clk, .rst_b, .clk_en, .op_valid, .op_code, .exec_cond, .op_diff, .dst_area,
        .ptr_fault, .operand_a, .operand_b, .op_busy, .res_done, .res_lo_we, .res_hi_we, .res_lo, .res_hi,
        .carry_flag, .zero_flag, .error_flag, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    bwa_word_model mem (.core_clk, .rst_b, .lo_we(res_lo_we), .hi_we(res_hi_we), .dst_idx(4'h4),
        .lo(res_lo), .hi(res_hi));
    // 100 MHz clock
    always #5 core_clk = ~core_clk;
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            $display("unexpected timeout: expected done, seen hang");
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, ex, got);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // one-cycle register read, data judged in the following cycle
    task automatic rd(input logic [4:0] a, input logic [31:0] ex);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", ex, reg_rdata);
    endtask
    task automatic irq_is(input logic ex);
        repeat (2) @(posedge core_clk);
        #1;
        chk("irq", ex, irq);
    endtask
    // present one instruction, wait for completion, judge pulses, flags and memory
    task automatic run_op(input logic [1:0] op, input logic [15:0] a, b, input logic cnd, dif,
        input logic [2:0] dst, input logic flt, wl, wh, input logic [15:0] el, eh, input logic ec, ez, ee);
        logic [15:0] o0, o1;
        int n;
        o0 = mem.mem_ff[4];
        o1 = mem.mem_ff[5];
        n = 1;
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= op;
        operand_a <= a;
        operand_b <= b;
        exec_cond <= cnd;
        op_diff <= dif;
        dst_area <= dst;
        ptr_fault <= flt;
        @(posedge core_clk);
        op_valid <= 1'b0;
        #1;
        chk("op_busy", op == 2'h3 && wl, op_busy);
        while (n < 40 && res_done !== 1'b1)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("latency", (op == 2'h3 && wl) ? 18 : 1, n);
        chk("res_lo_we", wl, res_lo_we);
        chk("res_hi_we", wh, res_hi_we);
        chk("carry_flag", ec, carry_flag);
        chk("zero_flag", ez, zero_flag);
        chk("error_flag", ee, error_flag);
        @(posedge core_clk);
        #1;
        chk("word_r", wl ? el : o0, mem.mem_ff[4]);
        chk("word_r1", wh ? eh : o1, mem.mem_ff[5]);
    endtask
    task automatic t_regs();
        rd(bwa_pkg::REG_FLAGS, 32'h0);
        rd(bwa_pkg::REG_INT_ENABLE, 32'h0);
        wr(5'h1C, 32'hFFFFFFFF);
        rd(5'h1C, 32'h0);
        rd(bwa_pkg::REG_INT_ENABLE, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_add();
        wr(bwa_pkg::REG_CARRY_CTRL, 32'h2);
        run_op(2'h0, 16'hA6E2, 16'h80C5, 1, 0, 3'h3, 0, 1, 0, 16'h27A7, 0, 1, 0, 0);
        run_op(2'h0, 16'h0000, 16'h0000, 1, 0, 3'h3, 0, 1, 0, 16'h0001, 0, 0, 0, 0);
        run_op(2'h0, 16'hFFFF, 16'h0001, 1, 0, 3'h3, 0, 1, 0, 16'h0000, 0, 1, 1, 0);
        rd(bwa_pkg::REG_FLAGS, 32'h3);
        $display("test add done");
    endtask
    task automatic t_sub();
        wr(bwa_pkg::REG_CARRY_CTRL, 32'h2);
        run_op(2'h1, 16'h5A10, 16'h60E3, 1, 0, 3'h3, 0, 1, 0, 16'hF92D, 0, 1, 0, 0);
        run_op(2'h1, 16'h20F5, 16'hB8A3, 1, 0, 3'h3, 0, 1, 0, 16'h6851, 0, 1, 0, 0);
        run_op(2'h1, 16'h0005, 16'h0004, 1, 0, 3'h3, 0, 1, 0, 16'h0000, 0, 0, 1, 0);
        $display("test sub done");
    endtask
    task automatic t_muldiv();
        run_op(2'h2, 16'hFFFF, 16'hFFFF, 1, 0, 3'h3, 0, 1, 1, 16'h0001, 16'hFFFE, 0, 0, 0);
        run_op(2'h2, 16'h0100, 16'h0100, 1, 0, 3'h3, 0, 1, 1, 16'h0000, 16'h0001, 0, 0, 0);
        run_op(2'h2, 16'h0000, 16'h1234, 1, 0, 3'h3, 0, 1, 1, 16'h0000, 16'h0000, 0, 1, 0);
        run_op(2'h3, 16'h1234, 16'h0010, 1, 0, 3'h3, 0, 1, 1, 16'h0123, 16'h0004, 0, 0, 0);
        run_op(2'h3, 16'h0003, 16'h0007, 1, 0, 3'h3, 0, 1, 1, 16'h0000, 16'h0003, 0, 1, 0);
        run_op(2'h3, 16'h1234, 16'h0000, 1, 0, 3'h3, 0, 0, 0, 0, 0, 0, 1, 1);
        $display("test muldiv done");
    endtask
    task automatic t_cond();
        for (int i = 0; i < 4; i++)
            run_op(2'(i), 16'hFFFF, 16'h0001, 0, 0, 3'h3, 0, 0, 0, 0, 0, 0, 1, 1);
        run_op(2'h0, 16'h0001, 16'h0002, 1, 1, 3'h3, 0, 1, 0, 16'h0003, 0, 0, 0, 0);
        run_op(2'h0, 16'h0005, 16'h0005, 1, 1, 3'h3, 0, 0, 0, 0, 0, 0, 0, 0);
        $display("test cond done");
    endtask
    task automatic t_err();
        logic ok;
        for (int i = 0; i < 4; i++)
            run_op(2'(i), 16'h0001, 16'h0001, 1, 0, 3'h3, 1, 0, 0, 0, 0, 0, 0, 1);
        for (int i = 0; i < 8; i++)
        begin
            ok = (i == 0 || i == 2 || i == 3 || i == 4 || i == 6);
            run_op(2'h0, 16'h0000, 16'h0000, 1, 0, 3'(i), 0, ok, 0, 0, 0, 0, 1, !ok);
        end
        $display("test err done");
    endtask
    task automatic t_irq();
        wr(bwa_pkg::REG_INT_CLEAR, 32'h3);
        wr(bwa_pkg::REG_INT_ENABLE, 32'h2);
        rd(bwa_pkg::REG_INT_ENABLE, 32'h2);
        irq_is(1'b0);
        run_op(2'h0, 16'h0001, 16'h0001, 1, 0, 3'h3, 1, 0, 0, 0, 0, 0, 1, 1);
        irq_is(1'b1);
        rd(bwa_pkg::REG_INT_STATUS, 32'h3);
        wr(bwa_pkg::REG_INT_ENABLE, 32'h0);
        irq_is(1'b0);
        wr(bwa_pkg::REG_INT_ENABLE, 32'h2);
        irq_is(1'b1);
        wr(bwa_pkg::REG_INT_CLEAR, 32'h2);
        irq_is(1'b0);
        rd(bwa_pkg::REG_INT_STATUS, 32'h1);
        wr(bwa_pkg::REG_CARRY_CTRL, 32'h1);
        rd(bwa_pkg::REG_FLAGS, 32'h7);
        // a carry clear while the enable is low must not land
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(bwa_pkg::REG_CARRY_CTRL, 32'h2);
        clk_en <= 1'b1;
        rd(bwa_pkg::REG_FLAGS, 32'h7);
        $display("test irq done");
    endtask
    // reset, then the scenarios in order
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        t_regs();
        t_add();
        t_sub();
        t_muldiv();
        t_cond();
        t_err();
        t_irq();
        summarize();
    end
endmodule // binary_word_arith_unit_tb_top
`default_nettype wire
